// [irq_wdt_pkg.sv]
package irq_wdt_pkg;

  localparam int CLK_MHZ = 25;
  localparam int VEC_W = 10;
  localparam logic [9:0] VEC_SW_TRAP = 10'h001;
  localparam logic [9:0] VEC_HW_IRQ = 10'h008;

  // Bit positions in the flag and enable registers
  localparam int BIT_TIMER0 = 0;
  localparam int BIT_TIMER1 = 1;
  localparam int BIT_PORTB = 2;
  localparam int BIT_EXT = 3;
  localparam int BIT_LOW_SUPPLY = 4;
  localparam int BIT_WATCHDOG = 6;
  localparam logic [7:0] IRQ_USED_MASK = 8'h5F;

  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic GIE_RST = 1'b0;
  localparam logic TIMEOUT_N_RST = 1'b1;

  // Watchdog base periods in microseconds
  localparam int WDT_T0_US = 3500;
  localparam int WDT_T1_US = 15000;
  localparam int WDT_T2_US = 60000;
  localparam int WDT_T3_US = 250000;
  localparam int WDT_T0_CYC = WDT_T0_US * CLK_MHZ;
  localparam int WDT_T1_CYC = WDT_T1_US * CLK_MHZ;
  localparam int WDT_T2_CYC = WDT_T2_US * CLK_MHZ;
  localparam int WDT_T3_CYC = WDT_T3_US * CLK_MHZ;
  localparam int WDT_CNT_W = 24;
  localparam int PRESC_W = 9;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SW_VEC,
    ST_HW_VEC
  } vec_state_t;

endpackage

// [irq_flag_bank.sv]
`timescale 1ns/100ps
module irq_flag_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] set_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] flag_o
);

  logic [7:0] flag_reg;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      logic clr;
      assign clr = wr_i && !wdata_i[g];
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flag_reg[g] <= irq_wdt_pkg::FLAG_RST[g];
        end else if (set_i[g]) begin
          flag_reg[g] <= 1'b1; // RQ24
        end else if (clr) begin
          flag_reg[g] <= 1'b0; // RQ5
        end
      end
    end
  endgenerate

  assign flag_o = flag_reg & irq_wdt_pkg::IRQ_USED_MASK;

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (set_i[0] && wr_i && !wdata_i[0]) |=> flag_o[0]) // RQ24
    else $error("flag lost when set met clear");

endmodule

// [watchdog_timer.sv]
`timescale 1ns/100ps
module watchdog_timer #(
  parameter int T0_CYC = irq_wdt_pkg::WDT_T0_CYC,
  parameter int T1_CYC = irq_wdt_pkg::WDT_T1_CYC,
  parameter int T2_CYC = irq_wdt_pkg::WDT_T2_CYC,
  parameter int T3_CYC = irq_wdt_pkg::WDT_T3_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] period_sel_i,
  input wire logic presc_on_i,
  input wire logic [2:0] ratio_sel_i,
  input wire logic irq_mode_i,
  output logic expire_o
);

  logic [irq_wdt_pkg::WDT_CNT_W-1:0] base_reg;
  logic [irq_wdt_pkg::WDT_CNT_W-1:0] base_last;
  logic [irq_wdt_pkg::PRESC_W-1:0] presc_reg;
  logic [irq_wdt_pkg::PRESC_W-1:0] presc_last;
  logic base_tick;

  always_comb begin
    case (period_sel_i) // RQ18
      2'h0: base_last = irq_wdt_pkg::WDT_CNT_W'(T0_CYC - 1);
      2'h1: base_last = irq_wdt_pkg::WDT_CNT_W'(T1_CYC - 1);
      2'h2: base_last = irq_wdt_pkg::WDT_CNT_W'(T2_CYC - 1);
      default: base_last = irq_wdt_pkg::WDT_CNT_W'(T3_CYC - 1);
    endcase
  end

  // Reset mode divides 1..128, interrupt mode 2..256
  assign presc_last = presc_on_i ?
    (({{(irq_wdt_pkg::PRESC_W-1){1'b0}}, 1'b1} << ratio_sel_i)
      << irq_mode_i) - 9'h001 : 9'h000; // RQ19 RQ20
  assign base_tick = run_i && (base_reg == base_last);
  assign expire_o = base_tick && (presc_reg >= presc_last);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg <= '0;
    end else if (clear_i || !run_i || base_tick) begin
      base_reg <= '0; // RQ21
    end else begin
      base_reg <= base_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_reg <= '0;
    end else if (clear_i || !run_i || expire_o) begin
      presc_reg <= '0; // RQ21
    end else if (base_tick) begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

endmodule

// [irq_and_watchdog_unit.sv]
`timescale 1ns/100ps
// Function
// RQ1: Six hardware sources, timers, watchdog, port B, external, low supply.
// RQ2: Hardware requests need global enable, set and cleared by instructions.
// RQ3: Trap vectors to 0x001 whatever the enable, and clears global enable.
// RQ4: Return sets global enable and resumes the interrupted sequence.
// RQ5: Each event sets its sticky flag; only firmware writing 0 clears it.
// RQ6: A flag reads back set only when its enable bit is 1.
// RQ7: Flag, enable and global enable all set: vector to 0x008, clear global.
// RQ8: Firmware must not put enable right before return-from-interrupt.
// RQ9: Timer0 overflow sets its flag; serviced with its enable and global.
// RQ10: Timer1 underflow sets its flag; serviced with its enable and global.
// RQ11: Watchdog expiry in interrupt mode sets flag bit 6.
// RQ12: Change on a wake-selected input pin of port B sets the change flag.
// RQ13: External select on pin zero disables change detection there.
// RQ14: Selected edge on pin zero, under external select, sets its flag.
// RQ15: Low-supply detector falling edge sets the low-supply flag.
// RQ16: Configuration enables watchdog; run enable starts and stops it.
// RQ17: Expiry resets or interrupts per configuration; clears timeout status.
// RQ18: Base timeout is 3.5, 15, 60 or 250 ms by a two-bit selection.
// RQ19: Prescaler routed to watchdog lengthens timeout by the selected ratio.
// RQ20: Ratio spans 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode.
// RQ21: Clear-watchdog clears counter and prescaler, sets timeout status to 1; an expiry in the same cycle wins here and sets it to 0.
// RQ22: Watchdog keeps counting regardless of core standby or halt.
// RQ23: Detector works only when its enable is 1; live level is readable.
// RQ24: A hardware set in the same cycle as a firmware clear wins.
module irq_and_watchdog_unit #(
  parameter int WDT_T0_CYC = irq_wdt_pkg::WDT_T0_CYC,
  parameter int WDT_T1_CYC = irq_wdt_pkg::WDT_T1_CYC,
  parameter int WDT_T2_CYC = irq_wdt_pkg::WDT_T2_CYC,
  parameter int WDT_T3_CYC = irq_wdt_pkg::WDT_T3_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_underflow_i,
  input wire logic [7:0] portb_pins_i,
  input wire logic [7:0] portb_is_input_i,
  input wire logic [7:0] portb_wake_select_i,
  input wire logic ext_irq_select_i,
  input wire logic ext_edge_select_i,
  input wire logic low_supply_detect_on_i,
  input wire logic low_supply_comp_i,
  input wire logic enable_irqs_instr_i,
  input wire logic disable_irqs_instr_i,
  input wire logic sw_trap_instr_i,
  input wire logic return_from_isr_instr_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic flag_wr_i,
  input wire logic [7:0] flag_wdata_i,
  input wire logic enable_wr_i,
  input wire logic [7:0] enable_wdata_i,
  input wire logic wdt_cfg_enable_i,
  input wire logic wdt_cfg_irq_mode_i,
  input wire logic [1:0] wdt_cfg_period_sel_i,
  input wire logic watchdog_run_enable_i,
  input wire logic prescaler_to_watchdog_i,
  input wire logic [2:0] prescaler_ratio_sel_i,
  output logic global_irq_enable_o,
  output logic vector_fetch_o,
  output logic [9:0] vector_addr_o,
  output logic [7:0] irq_flag_reg_o,
  output logic [7:0] irq_enable_reg_o,
  output logic timeout_status_n_o,
  output logic watchdog_reset_o,
  output logic low_supply_level_o
);

  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  logic rst_meta_reg;
  logic rst_n_reg;
  logic rst_n;
  logic primed_reg;
  logic [7:0] portb_prev_reg;
  logic lvd_prev_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] flags;
  logic [7:0] set_vec;
  logic [7:0] pb_watch;
  logic pb_change;
  logic ext_edge;
  logic lvd_fall;
  logic wdt_run;
  logic wdt_expire;
  logic gie_reg;
  logic gie_next;
  logic timeout_n_reg;
  logic wdt_reset_reg;
  logic lvd_level_reg;
  logic hw_pending;
  logic hw_take;
  irq_wdt_pkg::vec_state_t state_reg;
  irq_wdt_pkg::vec_state_t state_next;
  logic [9:0] vec_addr_reg;

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // Edge history; first sample only primes it to avoid a bogus change
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      primed_reg <= 1'b0;
      portb_prev_reg <= 8'h00;
      lvd_prev_reg <= 1'b1;
    end else begin
      primed_reg <= 1'b1;
      portb_prev_reg <= portb_pins_i;
      lvd_prev_reg <= low_supply_comp_i;
    end
  end

  assign pb_watch = portb_is_input_i & portb_wake_select_i &
                    {7'h7F, !ext_irq_select_i}; // RQ13
  assign pb_change = primed_reg &&
                     |((portb_pins_i ^ portb_prev_reg) & pb_watch); // RQ12
  assign ext_edge = primed_reg && ext_irq_select_i &&
                    edge_hit(portb_prev_reg[0], portb_pins_i[0],
                             ext_edge_select_i); // RQ14
  // Detector ignored while switched off
  assign lvd_fall = primed_reg && low_supply_detect_on_i && // RQ15 RQ23
                    edge_hit(lvd_prev_reg, low_supply_comp_i, 1'b0);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvd_level_reg <= 1'b1;
    end else begin
      lvd_level_reg <= low_supply_detect_on_i ?
                       low_supply_comp_i : 1'b1; // RQ23
    end
  end

  // Watchdog, counted on the always-running reference clock
  assign wdt_run = wdt_cfg_enable_i && watchdog_run_enable_i; // RQ16 RQ22

  watchdog_timer #(
    .T0_CYC(WDT_T0_CYC),
    .T1_CYC(WDT_T1_CYC),
    .T2_CYC(WDT_T2_CYC),
    .T3_CYC(WDT_T3_CYC)
  ) u_wdt (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .run_i(wdt_run),
    .clear_i(clear_watchdog_instr_i),
    .period_sel_i(wdt_cfg_period_sel_i),
    .presc_on_i(prescaler_to_watchdog_i),
    .ratio_sel_i(prescaler_ratio_sel_i),
    .irq_mode_i(wdt_cfg_irq_mode_i),
    .expire_o(wdt_expire)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timeout_n_reg <= irq_wdt_pkg::TIMEOUT_N_RST;
    end else if (wdt_expire) begin
      timeout_n_reg <= 1'b0; // RQ17
    end else if (clear_watchdog_instr_i) begin
      timeout_n_reg <= 1'b1; // RQ21
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset_reg <= 1'b0;
    end else begin
      wdt_reset_reg <= wdt_expire && !wdt_cfg_irq_mode_i; // RQ17
    end
  end

  // Flag sources
  always_comb begin
    set_vec = 8'h00;
    set_vec[irq_wdt_pkg::BIT_TIMER0] = timer0_overflow_i; // RQ9
    set_vec[irq_wdt_pkg::BIT_TIMER1] = timer1_underflow_i; // RQ10
    set_vec[irq_wdt_pkg::BIT_PORTB] = pb_change; // RQ12
    set_vec[irq_wdt_pkg::BIT_EXT] = ext_edge; // RQ14
    set_vec[irq_wdt_pkg::BIT_LOW_SUPPLY] = lvd_fall; // RQ15
    set_vec[irq_wdt_pkg::BIT_WATCHDOG] = wdt_expire &&
                                         wdt_cfg_irq_mode_i; // RQ11
  end

  irq_flag_bank u_flags (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .set_i(set_vec),
    .wr_i(flag_wr_i),
    .wdata_i(flag_wdata_i),
    .flag_o(flags)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= irq_wdt_pkg::ENABLE_RST;
    end else if (enable_wr_i) begin
      irq_enable_reg <= enable_wdata_i & irq_wdt_pkg::IRQ_USED_MASK;
    end
  end

  // Masked readback; raw flags stay hidden behind their enables
  assign irq_flag_reg_o = flags & irq_enable_reg; // RQ6
  assign irq_enable_reg_o = irq_enable_reg;

  assign hw_pending = |(flags & irq_enable_reg); // RQ1
  // One vector at a time; trap beats a hardware request
  assign hw_take = (state_reg == irq_wdt_pkg::ST_RUN) &&
                   !sw_trap_instr_i && gie_reg && hw_pending; // RQ2 RQ7

  always_comb begin
    gie_next = gie_reg;
    if (sw_trap_instr_i || hw_take) begin
      gie_next = 1'b0; // RQ3 RQ7
    end else if (disable_irqs_instr_i) begin
      gie_next = 1'b0; // RQ2
    end else if (enable_irqs_instr_i || return_from_isr_instr_i) begin
      gie_next = 1'b1; // RQ2 RQ4
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gie_reg <= irq_wdt_pkg::GIE_RST;
    end else begin
      gie_reg <= gie_next;
    end
  end

  always_comb begin
    case (state_reg)
      irq_wdt_pkg::ST_RUN: begin
        if (sw_trap_instr_i) begin
          state_next = irq_wdt_pkg::ST_SW_VEC; // RQ3
        end else if (hw_take) begin
          state_next = irq_wdt_pkg::ST_HW_VEC; // RQ7
        end else begin
          state_next = irq_wdt_pkg::ST_RUN;
        end
      end
      default: state_next = irq_wdt_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= irq_wdt_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vec_addr_reg <= irq_wdt_pkg::VEC_HW_IRQ;
    end else if (state_next == irq_wdt_pkg::ST_SW_VEC) begin
      vec_addr_reg <= irq_wdt_pkg::VEC_SW_TRAP; // RQ3
    end else if (state_next == irq_wdt_pkg::ST_HW_VEC) begin
      vec_addr_reg <= irq_wdt_pkg::VEC_HW_IRQ; // RQ7
    end
  end

  assign global_irq_enable_o = gie_reg;
  assign vector_fetch_o = (state_reg != irq_wdt_pkg::ST_RUN);
  assign vector_addr_o = vec_addr_reg;
  assign timeout_status_n_o = timeout_n_reg;
  assign watchdog_reset_o = wdt_reset_reg;
  assign low_supply_level_o = lvd_level_reg;

  AST_TRAP_VECTOR: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (sw_trap_instr_i && state_reg == irq_wdt_pkg::ST_RUN) |=>
      vector_fetch_o && vector_addr_o == 10'h001 &&
      !global_irq_enable_o) // RQ3
    else $error("trap did not vector to 0x001");

  AST_HW_VECTOR: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    hw_take |=> vector_fetch_o && vector_addr_o == 10'h008 &&
      !global_irq_enable_o) // RQ7
    else $error("hardware request did not vector to 0x008");

  AST_NO_IRQ_WHEN_OFF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n)
    (!global_irq_enable_o && !sw_trap_instr_i) |=> !vector_fetch_o) // RQ2
    else $error("vector taken with global enable clear");

  AST_RETURN_SETS_GIE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n)
    (return_from_isr_instr_i && !sw_trap_instr_i && !hw_take &&
     !disable_irqs_instr_i) |=> global_irq_enable_o) // RQ4
    else $error("return did not set global enable");

  AST_FLAG_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (flags[irq_wdt_pkg::BIT_TIMER0] && !flag_wr_i) |=>
      flags[irq_wdt_pkg::BIT_TIMER0]) // RQ5
    else $error("flag dropped without firmware write");

  AST_TIMER1_SETS: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    timer1_underflow_i |=> flags[irq_wdt_pkg::BIT_TIMER1]) // RQ10
    else $error("timer1 underflow lost");

  AST_MASKED_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (irq_flag_reg_o & ~irq_enable_reg_o) == 8'h00) // RQ6
    else $error("flag visible without enable");

  AST_PB0_MASKED: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (ext_irq_select_i && $changed(portb_pins_i[0]) &&
     portb_pins_i[7:1] == $past(portb_pins_i[7:1])) |-> !pb_change) // RQ13
    else $error("pin zero change seen while external select");

  AST_WDT_TIMEOUT_BIT: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n)
    wdt_expire |=> !timeout_status_n_o) // RQ17
    else $error("timeout status not cleared on expiry");

  AST_CLEAR_WATCHDOG_INSTR_SETS: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clear_watchdog_instr_i && !wdt_expire) |=> timeout_status_n_o) // RQ21
    else $error("clear-watchdog did not set timeout status");

  AST_WDT_IRQ_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wdt_expire && wdt_cfg_irq_mode_i) |=>
      flags[irq_wdt_pkg::BIT_WATCHDOG] && !watchdog_reset_o) // RQ11
    else $error("watchdog interrupt mode misbehaved");

  AST_LVD_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (!low_supply_detect_on_i && !flags[irq_wdt_pkg::BIT_LOW_SUPPLY]) |=>
      !flags[irq_wdt_pkg::BIT_LOW_SUPPLY]) // RQ23
    else $error("detector event while switched off");

  COV_TRAP: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    sw_trap_instr_i ##1 vector_fetch_o);
  COV_HW: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    hw_take ##1 vector_fetch_o ##[1:20] return_from_isr_instr_i);
  COV_WDT_RESET: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    watchdog_reset_o);

endmodule

// [core_fetch_model.sv]
`timescale 1ns/100ps
module core_fetch_model (
  input wire logic clk_i,
  output logic enable_irqs_o,
  output logic disable_irqs_o,
  output logic sw_trap_o,
  output logic return_o,
  output logic clear_wdt_o
);
  // One-hot decode: 0 enable, 1 disable, 2 trap, 3 return, 4 clear
  logic [4:0] op_hot;

  assign enable_irqs_o = op_hot[0];
  assign disable_irqs_o = op_hot[1];
  assign sw_trap_o = op_hot[2];
  assign return_o = op_hot[3];
  assign clear_wdt_o = op_hot[4];

  initial begin
    op_hot = 5'h00;
  end

  // Called at a falling edge; each opcode is a one-cycle pulse
  task automatic issue(input logic [2:0] code);
    // Idle slot first, so enable never sits right before return
    @(negedge clk_i);
    op_hot = 5'h01 << code;
    @(negedge clk_i);
    op_hot = 5'h00;
  endtask
endmodule

// [irq_and_watchdog_unit_tb_top.sv]
`timescale 1ns/100ps
module irq_and_watchdog_unit_tb_top;
  localparam int BASE [4] = '{8, 16, 32, 64};
  localparam int SRC [5] = '{irq_wdt_pkg::BIT_TIMER0,
    irq_wdt_pkg::BIT_TIMER1, irq_wdt_pkg::BIT_PORTB,
    irq_wdt_pkg::BIT_EXT, irq_wdt_pkg::BIT_LOW_SUPPLY};
  logic ref_clk_i, arst_n_i, t0_ovf, t1_unf, ext_sel, edge_sel;
  logic sup_on, sup_ok, fwr, ewr, wen, wirq, wrun, pwd;
  logic eni_p, disable_irqs_instr_p, trap_p, reti_p, clr_p, g_en, vf, to_n, wrst, lvl;
  logic [7:0] pins, pin_in, wake_sel, fwd, ewd, flags, enables;
  logic [9:0] vaddr;
  logic [2:0] psel, p;
  logic [1:0] wper;
  logic [31:0] seed = 32'h6C0CCB46;
  int errors = 0;
  int checked = 0;
  int n;

  irq_and_watchdog_unit #(
    .WDT_T0_CYC(BASE[0]), .WDT_T1_CYC(BASE[1]),
    .WDT_T2_CYC(BASE[2]), .WDT_T3_CYC(BASE[3])
  ) i_irq_and_watchdog_unit (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .timer0_overflow_i(t0_ovf), .timer1_underflow_i(t1_unf),
    .portb_pins_i(pins), .portb_is_input_i(pin_in),
    .portb_wake_select_i(wake_sel), .ext_irq_select_i(ext_sel),
    .ext_edge_select_i(edge_sel), .low_supply_detect_on_i(sup_on),
    .low_supply_comp_i(sup_ok), .enable_irqs_instr_i(eni_p),
    .disable_irqs_instr_i(disable_irqs_instr_p), .sw_trap_instr_i(trap_p),
    .return_from_isr_instr_i(reti_p), .clear_watchdog_instr_i(clr_p),
    .flag_wr_i(fwr), .flag_wdata_i(fwd), .enable_wr_i(ewr),
    .enable_wdata_i(ewd), .wdt_cfg_enable_i(wen),
    .wdt_cfg_irq_mode_i(wirq), .wdt_cfg_period_sel_i(wper),
    .watchdog_run_enable_i(wrun), .prescaler_to_watchdog_i(pwd),
    .prescaler_ratio_sel_i(psel), .global_irq_enable_o(g_en),
    .vector_fetch_o(vf), .vector_addr_o(vaddr), .irq_flag_reg_o(flags),
    .irq_enable_reg_o(enables), .timeout_status_n_o(to_n),
    .watchdog_reset_o(wrst), .low_supply_level_o(lvl)
  );

  core_fetch_model i_core_fetch_model (
    .clk_i(ref_clk_i), .enable_irqs_o(eni_p), .disable_irqs_o(disable_irqs_instr_p),
    .sw_trap_o(trap_p), .return_o(reti_p), .clear_wdt_o(clr_p)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int wdt_cycles(input logic irqm, input logic [1:0] per,
                                    input logic pon, input logic [2:0] ps);
    if (!pon)
      return BASE[per];
    // Interrupt mode gets one extra divide stage
    return BASE[per] << (irqm ? ps + 1 : ps);
  endfunction

  task automatic tick(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic [2:0] code);
    i_core_fetch_model.issue(code);
  endtask

  // Trailing idle cycle keeps strobes from being re-raised in one step
  task automatic fwrite(input logic [7:0] v);
    fwd = v;
    fwr = 1'b1;
    tick(1);
    fwr = 1'b0;
    tick(1);
  endtask

  task automatic ewrite(input logic [7:0] v);
    ewd = v;
    ewr = 1'b1;
    tick(1);
    ewr = 1'b0;
    tick(1);
  endtask

  task automatic wdt(input logic irqm, input logic [1:0] per,
                     input logic pon, input logic [2:0] ps);
    wirq = irqm;
    wper = per;
    pwd = pon;
    psel = ps;
    op(3'd4);
    chk(to_n, 1'b1);
    fwrite(8'h00);
    n = 3;
    while (to_n !== 1'b0 && n < 20000) begin
      tick(1);
      n++;
    end
    chk(n, wdt_cycles(irqm, per, pon, ps) + 1);
    chk(wrst, !irqm);
    chk(flags[6], irqm);
    tick(1);
    chk(wrst, 1'b0);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(40 * 60000);
    errors++;
    end_sim();
  end

  initial begin
    {t0_ovf, t1_unf, ext_sel, edge_sel, sup_on, fwr, ewr} = '0;
    {wen, wirq, wrun, pwd, pins, wake_sel, fwd, ewd, wper, psel} = '0;
    sup_ok = 1'b1;
    pin_in = 8'hFF;
    arst_n_i = 1'b0;
    tick(2);
    arst_n_i = 1'b1;
    tick(4);
    chk(g_en, irq_wdt_pkg::GIE_RST);
    chk(flags, irq_wdt_pkg::FLAG_RST);
    chk(to_n, irq_wdt_pkg::TIMEOUT_N_RST);
    chk(lvl, 1'b1);
    for (int i = 0; i < 2; i++) begin
      op(3'd1);
      chk(g_en, 1'b0);
      if (i == 1)
        op(3'd0);
      chk(g_en, i);
      op(3'd2);
      chk(vf, 1'b1);
      chk(vaddr, irq_wdt_pkg::VEC_SW_TRAP);
      chk(g_en, 1'b0);
      tick(1);
      chk(vf, 1'b0);
      op(3'd3);
      chk(g_en, 1'b1);
    end
    op(3'd1);
    ewrite(irq_wdt_pkg::IRQ_USED_MASK);
    chk(enables, irq_wdt_pkg::IRQ_USED_MASK);
    wake_sel = 8'hFF;
    ext_sel = 1'b1;
    edge_sel = 1'b1;
    sup_on = 1'b1;
    tick(3);
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      p = seed[2:0] | 3'd1;
      pin_in = seed[15:8] | 8'h01 | (8'h01 << p);
      case (k)
        0: t0_ovf = 1'b1;
        1: t1_unf = 1'b1;
        2: pins[p] = ~pins[p];
        3: pins[0] = 1'b1;
        default: sup_ok = 1'b0;
      endcase
      tick(1);
      {t0_ovf, t1_unf} = 2'b00;
      tick(3);
      chk(flags, 8'h01 << SRC[k]);
      fwrite(8'hFF);
      chk(flags, 8'h01 << SRC[k]);
      fwrite(8'h00);
      chk(flags, 8'h00);
    end
    chk(lvl, 1'b0);
    pins[0] = 1'b0;
    tick(3);
    chk(flags, 8'h00);
    edge_sel = 1'b0;
    tick(2);
    pins[0] = 1'b1;
    tick(3);
    pins[0] = 1'b0;
    tick(3);
    chk(flags, 8'h01 << irq_wdt_pkg::BIT_EXT);
    fwrite(8'h00);
    pin_in = 8'h00;
    pins = ~pins;
    sup_ok = 1'b1;
    tick(3);
    chk(flags, 8'h00);
    chk(lvl, 1'b1);
    sup_on = 1'b0;
    tick(2);
    sup_ok = 1'b0;
    tick(3);
    chk(flags, 8'h00);
    chk(lvl, 1'b1);
    {sup_ok, ext_sel, pin_in} = {2'b10, 8'hFF};
    seed = lfsr(seed);
    ewrite(seed[7:0]);
    chk(enables, seed[7:0] & irq_wdt_pkg::IRQ_USED_MASK);
    {t0_ovf, t1_unf} = 2'b11;
    tick(1);
    {t0_ovf, t1_unf} = 2'b00;
    chk(flags, {6'h00, seed[1:0]});
    ewrite(irq_wdt_pkg::IRQ_USED_MASK);
    chk(flags, 8'h03);
    // Same-edge set and clear: the event must survive
    t1_unf = 1'b1;
    fwd = 8'h00;
    fwr = 1'b1;
    tick(1);
    {t1_unf, fwr} = 2'b00;
    chk(flags, 8'h02);
    fwrite(8'h00);
    ewrite(8'h01);
    t0_ovf = 1'b1;
    tick(1);
    t0_ovf = 1'b0;
    tick(2);
    chk(vf, 1'b0);
    op(3'd0);
    tick(1);
    chk(vf, 1'b1);
    chk(vaddr, irq_wdt_pkg::VEC_HW_IRQ);
    chk(g_en, 1'b0);
    fwrite(8'h00);
    op(3'd3);
    tick(2);
    chk(vf, 1'b0);
    op(3'd1);
    ewrite(8'h40);
    {wen, wrun} = 2'b11;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      if (i < 4)
        wdt(1'b1, i[1:0], 1'b0, 3'd0);
      else
        wdt((seed[8] | (i == 4)) & (i != 5), 2'd0, 1'b1,
            (i == 4) ? 3'd7 : seed[2:0]);
    end
    // Base period only, so a watchdog left running would expire here
    {wrun, pwd} = 2'b00;
    op(3'd4);
    tick(100);
    chk(to_n, 1'b1);
    {wen, wrun} = 2'b01;
    tick(100);
    chk(to_n, 1'b1);
    end_sim();
  end
endmodule
